// ===== design/sram_burst_data_port.sv
// Load, burst sequencing and masked data path of the burst SRAM port
`timescale 1ns/10ps
module sram_burst_data_port
  import sram_burst_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Transaction load
  input  wire logic                load_strobe_n_i,
  input  wire logic                read_write_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  // Write data and masks
  input  wire logic [DQ_W-1:0]     dq_i,
  input  wire logic [NUM_BWS-1:0]  byte_write_sel_n_i,
  input  wire logic [NUM_NWS-1:0]  nibble_write_sel_n_i,
  // Read data
  output logic      [DQ_W-1:0]     dq_o,
  output logic                     dq_oe_o,
  output logic                     read_valid_out_o
);

  burst_state_e      state_reg;
  burst_state_e      state_next;
  logic              dir_read_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              load_take;
  logic              beat_wr;
  logic [DQ_W-1:0]   wr_bit_en;
  logic [WORD_AW-1:0] wr_addr;
  logic [WORD_AW-1:0] rd_addr;

  // Per-bit write enable from active-low lane selects
  function automatic logic [DQ_W-1:0] lane_mask(
    input logic [NUM_BWS-1:0] bws_n,
    input logic [NUM_NWS-1:0] nws_n
  );
    logic [DQ_W-1:0] m;
    m = '0;
    if (NIBBLE_MODE) begin
      for (int n = 0; n < NUM_NWS; n++) begin
        m[n*NIB_W +: NIB_W] = {NIB_W{~nws_n[n]}};
      end
    end else begin
      for (int l = 0; l < NUM_BWS; l++) begin
        m[l*LANE_W +: LANE_W] = {LANE_W{~bws_n[l]}};
      end
    end
    return m;
  endfunction

  // A load is taken only when no first beat is still pending
  // Limitation: a load refused in beat 0 is lost, not queued
  assign load_take = !load_strobe_n_i && (state_reg != ST_BEAT0);

  // Sequencer: load, then two beats; a load in the last beat chains
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  state_next = load_take ? ST_BEAT0 : ST_IDLE;
      ST_BEAT0: state_next = ST_BEAT1;
      ST_BEAT1: state_next = load_take ? ST_BEAT0 : ST_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address and direction captured at the load edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg     <= ADDR_RESET;
      dir_read_reg <= 1'b0;
    end else if (load_take) begin
      addr_reg     <= addr_i;
      dir_read_reg <= read_write_i;
    end
  end

  // Write beats: data and selects taken on the same edge
  assign beat_wr   = (state_reg != ST_IDLE) && !dir_read_reg;
  assign wr_addr   = {addr_reg, state_reg == ST_BEAT1};
  assign wr_bit_en = beat_wr ? lane_mask(byte_write_sel_n_i,
                                         nibble_write_sel_n_i)
                             : '0;

  // Read address runs one cycle ahead so data leaves a register
  always_comb begin
    if (state_reg == ST_BEAT0) begin
      rd_addr = {addr_reg, 1'b1};
    end else begin
      rd_addr = {addr_i, 1'b0};
    end
  end

  // Array read register doubles as the output register
  sram_word_store u_store (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .wr_addr_i   (wr_addr),
    .wr_data_i   (dq_i),
    .wr_bit_en_i (wr_bit_en),
    .rd_addr_i   (rd_addr),
    .rd_data_o   (dq_o)
  );

  // Drive enable and valid follow the read beats only
  // Built from the next state so drive lines up with the read register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_oe_o          <= 1'b0;
      read_valid_out_o <= 1'b0;
    end else begin
      dq_oe_o <= (state_next != ST_IDLE)
                 && (load_take ? read_write_i : dir_read_reg);
      read_valid_out_o <= (state_next != ST_IDLE)
                 && (load_take ? read_write_i : dir_read_reg);
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_LOAD_STARTS: assert property (
    (state_reg == ST_IDLE && !load_strobe_n_i) |=> state_reg == ST_BEAT0)
    else $error("load in idle did not start a burst");
  AST_ONLY_ON_LOAD: assert property (
    (state_reg == ST_IDLE && load_strobe_n_i) |=> state_reg == ST_IDLE)
    else $error("burst started without a load");
  AST_TWO_BEATS: assert property (
    $rose(state_reg == ST_BEAT0) |-> ##1 state_reg == ST_BEAT1)
    else $error("burst did not run two beats");
  AST_MID_LOAD_IGNORED: assert property (
    (state_reg == ST_BEAT0 && !load_strobe_n_i)
      |=> state_reg == ST_BEAT1 && $stable(addr_reg))
    else $error("load during first beat disturbed the burst");
  AST_READ_DRIVES_TWO: assert property (
    (load_take && read_write_i) |=> dq_oe_o [*2])
    else $error("read burst not driven for two beats");
  AST_HIZ_IDLE: assert property (
    (state_reg == ST_IDLE || !dir_read_reg) |-> !dq_oe_o)
    else $error("outputs driven outside a read");
  AST_VALID_WITH_DATA: assert property (
    read_valid_out_o == dq_oe_o)
    else $error("valid indicator disagrees with drive");
  AST_ADDR_CAPTURE: assert property (
    load_take |=> addr_reg == $past(addr_i))
    else $error("address not captured at load");
  AST_READ_NO_WRITE: assert property (
    (load_take && read_write_i) |=> (wr_bit_en == '0) [*2])
    else $error("read burst wrote the array");
  AST_WRITE_BEATS: assert property (
    (load_take && !read_write_i) |=> beat_wr ##1 beat_wr)
    else $error("write burst missed a beat");
  AST_BYTE_MASK: assert property (
    (!NIBBLE_MODE && beat_wr && byte_write_sel_n_i[0])
      |-> wr_bit_en[LANE_W-1:0] == '0)
    else $error("deselected byte lane written");
  AST_BYTE_SEL: assert property (
    (!NIBBLE_MODE && beat_wr && !byte_write_sel_n_i[NUM_BWS-1])
      |-> &wr_bit_en[DQ_W-1 -: LANE_W])
    else $error("selected top byte lane not written");
  AST_NIBBLE_MASK: assert property (
    (NIBBLE_MODE && beat_wr && nibble_write_sel_n_i[1])
      |-> wr_bit_en[2*NIB_W-1:NIB_W] == '0)
    else $error("deselected nibble written");

  // Burst shape
  AST_BEAT1_FOLLOWS: assert property (
    state_reg == ST_BEAT1
      |-> $past(state_reg == ST_BEAT0))
    else $error("second beat without a first beat");

  AST_CHAIN_LOAD: assert property (
    (state_reg == ST_BEAT1 && load_take)
      |=> state_reg == ST_BEAT0)
    else $error("load in last beat did not chain");

  AST_DIR_HOLDS: assert property (
    state_reg == ST_BEAT0
      |=> $stable(dir_read_reg))
    else $error("direction changed inside a burst");

  AST_LOAD_DIR: assert property (
    load_take
      |=> dir_read_reg == $past(read_write_i))
    else $error("direction not captured at load");

  AST_IDLE_ADDR_KEEP: assert property (
    (state_reg == ST_IDLE && load_strobe_n_i)
      |=> $stable(addr_reg))
    else $error("address moved without a load");

  // Drive window
  AST_OE_FROM_READ: assert property (
    $rose(dq_oe_o)
      |-> $past(load_take && read_write_i))
    else $error("drive began without a read load");

  AST_OE_DROPS: assert property (
    (dq_oe_o && state_reg == ST_BEAT1 && !load_take)
      |=> !dq_oe_o)
    else $error("drive held after the read burst");

  AST_WRITE_NO_DRIVE: assert property (
    (load_take && !read_write_i)
      |=> !dq_oe_o [*2])
    else $error("outputs driven during a write burst");

  AST_OE_ONLY_BEATS: assert property (
    dq_oe_o
      |-> state_reg != ST_IDLE)
    else $error("outputs driven while idle");

  AST_VALID_ONLY_READ: assert property (
    read_valid_out_o
      |-> dir_read_reg)
    else $error("valid raised outside a read");

  // Address paths
  AST_BEAT0_ADDR: assert property (
    state_reg == ST_BEAT0
      |-> wr_addr[0] == 1'b0)
    else $error("first beat aimed at wrong word");

  AST_BEAT1_ADDR: assert property (
    state_reg == ST_BEAT1
      |-> wr_addr[0] == 1'b1)
    else $error("second beat aimed at wrong word");

  AST_WRITE_ADDR: assert property (
    (load_take && !read_write_i)
      |=> wr_addr == {$past(addr_i), 1'b0})
    else $error("write beat used a stale address");

  AST_RD_ADDR_LOAD: assert property (
    load_take
      |-> rd_addr == {addr_i, 1'b0})
    else $error("read of first word not issued at load");

  AST_RD_ADDR_BEAT1: assert property (
    state_reg == ST_BEAT0
      |-> rd_addr == {addr_reg, 1'b1})
    else $error("read of second word not issued");

  // Lane masks
  AST_IDLE_NO_WRITE: assert property (
    state_reg == ST_IDLE
      |-> wr_bit_en == '0)
    else $error("array written while idle");

  AST_BYTE_LOW_SEL: assert property (
    (!NIBBLE_MODE && beat_wr && !byte_write_sel_n_i[0])
      |-> &wr_bit_en[LANE_W-1:0])
    else $error("selected low byte lane not written");

  AST_TOP_MASK: assert property (
    (!NIBBLE_MODE && beat_wr && byte_write_sel_n_i[NUM_BWS-1])
      |-> wr_bit_en[DQ_W-1 -: LANE_W] == '0)
    else $error("deselected top byte lane written");

  AST_FULL_MASK: assert property (
    (!NIBBLE_MODE && beat_wr && byte_write_sel_n_i == '0)
      |-> &wr_bit_en)
    else $error("fully selected beat not fully written");

  COV_READ_BURST: cover property (
    (load_take && read_write_i) ##1 dq_oe_o ##1 dq_oe_o);
  COV_WRITE_BURST: cover property (
    (load_take && !read_write_i) ##1 beat_wr ##1 beat_wr);
  COV_CHAINED: cover property (
    state_reg == ST_BEAT1 && load_take);
  COV_MID_LOAD: cover property (
    state_reg == ST_BEAT0 && !load_strobe_n_i);
  // Write followed at once by a read
  COV_WRITE_THEN_READ: cover property (
    state_reg == ST_BEAT1 && !dir_read_reg && load_take && read_write_i);

endmodule

// ===== design/sram_burst_pkg.sv
// Shared constants and types for the burst SRAM data port
package sram_burst_pkg;

  // Data path geometry, widest variant
  localparam int DQ_W      = 36;
  localparam int LANE_W    = 9;
  localparam int NUM_BWS   = 4;
  localparam int NUM_NWS   = 2;
  localparam int NIB_W     = 4;

  // Selects the 8-bit nibble-masked variant instead of byte lanes
  localparam bit NIBBLE_MODE = 1'b0;

  // Model depth of the array, in burst addresses
  localparam int ADDR_W    = 8;
  localparam int WORD_AW   = ADDR_W + 1;

  // Words moved by every transaction
  localparam int BURST_LEN = 2;

  // Reset values
  localparam logic [DQ_W-1:0]   DQ_RESET   = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;

  // Burst sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BEAT0,
    ST_BEAT1
  } burst_state_e;

endpackage

// ===== design/sram_word_store.sv
// Bit-masked word array with registered read data
`timescale 1ns/10ps
module sram_word_store
  import sram_burst_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Write port, one enable per bit
  input  wire logic [WORD_AW-1:0] wr_addr_i,
  input  wire logic [DQ_W-1:0]    wr_data_i,
  input  wire logic [DQ_W-1:0]    wr_bit_en_i,
  // Read port
  input  wire logic [WORD_AW-1:0] rd_addr_i,
  output logic      [DQ_W-1:0]    rd_data_o
);

  logic [DQ_W-1:0] mem_array [2**WORD_AW];

  // Masked write, disabled bits keep their stored value
  always_ff @(posedge ref_clk_i) begin
    for (int b = 0; b < DQ_W; b++) begin
      if (wr_bit_en_i[b]) begin
        mem_array[wr_addr_i][b] <= wr_data_i[b];
      end
    end
  end

  // Read register, old data when read and write collide
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= DQ_RESET;
    end else begin
      rd_data_o <= mem_array[rd_addr_i];
    end
  end

endmodule

// ===== tb/sram_ctl_model.sv
// Memory controller model that drives the burst SRAM port
`timescale 1ns/10ps
module sram_ctl_model
  import sram_burst_pkg::*;
(
  // Clock
  input  wire logic               ref_clk_i,
  // Load and write data
  output logic                    load_strobe_n_o,
  output logic                    read_write_o,
  output logic      [ADDR_W-1:0]  addr_o,
  output logic      [DQ_W-1:0]    dq_o,
  output logic      [NUM_BWS-1:0] byte_write_sel_n_o,
  output logic      [NUM_NWS-1:0] nibble_write_sel_n_o
);
  logic [DQ_W-1:0]    pend_d = '0;
  logic [NUM_BWS-1:0] pend_m = '0;

  // Quiet bus at time zero
  initial begin
    load_strobe_n_o = 1'b1;
    read_write_o = 1'b1;
    addr_o = '0;
    dq_o = '0;
    byte_write_sel_n_o = '1;
    nibble_write_sel_n_o = '1;
  end

  // Load edge carries the previous burst's last beat, so bursts chain
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
    input logic [DQ_W-1:0] d0, d1, input logic [NUM_BWS-1:0] m0, m1,
    input logic bad);
    @(posedge ref_clk_i);
    load_strobe_n_o <= 1'b0;
    read_write_o <= rd;
    addr_o <= a;
    dq_o <= pend_d;
    byte_write_sel_n_o <= pend_m;
    @(posedge ref_clk_i);
    load_strobe_n_o <= ~bad;
    read_write_o <= ~rd;
    addr_o <= ~a;
    dq_o <= d0;
    byte_write_sel_n_o <= m0;
    nibble_write_sel_n_o <= NUM_NWS'($urandom);
    pend_d = d1;
    pend_m = m1;
  endtask

  // Released lines carry the pending last beat, then its inverse, never the last value
  task automatic idle();
    @(posedge ref_clk_i);
    load_strobe_n_o <= 1'b1;
    dq_o <= pend_d;
    byte_write_sel_n_o <= pend_m;
    pend_d = ~pend_d;
    pend_m = ~pend_m;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the burst SRAM data port
`timescale 1ns/10ps
module testbench;
  import sram_burst_pkg::*;
  logic                ref_clk_i;
  logic                rst_n_i;
  logic                ld_n;
  logic                rw;
  logic [ADDR_W-1:0]   addr;
  logic [DQ_W-1:0]     dq_in;
  logic [NUM_BWS-1:0]  bws_n;
  logic [NUM_NWS-1:0]  nws_n;
  logic [DQ_W-1:0]     dq_out;
  logic                dq_oe;
  logic                rd_vld;
  wire  [DQ_W-1:0]     dq_wire;
  logic [DQ_W-1:0]     shadow [0:2**WORD_AW-1];
  logic [DQ_W-1:0]     exp_q [$];
  int                  mismatches = 0;
  int                  checked = 0;

  // Floating bus when the device lets go
  assign dq_wire = dq_oe ? dq_out : 'z;

  sram_burst_data_port sram_burst_data_port_i (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .load_strobe_n_i(ld_n), .read_write_i(rw),
    .addr_i(addr), .dq_i(dq_in), .byte_write_sel_n_i(bws_n),
    .nibble_write_sel_n_i(nws_n), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .read_valid_out_o(rd_vld));
  sram_ctl_model sram_ctl_model_i (.ref_clk_i(ref_clk_i),
    .load_strobe_n_o(ld_n), .read_write_o(rw), .addr_o(addr),
    .dq_o(dq_in), .byte_write_sel_n_o(bws_n),
    .nibble_write_sel_n_o(nws_n));

  task automatic cmp36(input string n, input logic [DQ_W-1:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp1(input string n, input logic e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Active-low lane selects widened to a bit mask
  function automatic logic [DQ_W-1:0] lanes(input logic [NUM_BWS-1:0] m);
    for (int i = 0; i < NUM_BWS; i++) begin
      lanes[i*LANE_W +: LANE_W] = {LANE_W{~m[i]}};
    end
  endfunction

  // One burst; shadow and notes updated at issue, in bus order
  task automatic op(input logic rd, input int a, input logic full, bad);
    logic [DQ_W-1:0]    d0, d1;
    logic [NUM_BWS-1:0] m0, m1;
    logic [WORD_AW-1:0] w0, w1;
    d0 = DQ_W'({$urandom, $urandom});
    d1 = DQ_W'({$urandom, $urandom});
    m0 = full ? '0 : NUM_BWS'($urandom);
    m1 = full ? '0 : NUM_BWS'($urandom);
    w0 = {a[ADDR_W-1:0], 1'b0};
    w1 = {a[ADDR_W-1:0], 1'b1};
    if (rd) begin
      exp_q.push_back(shadow[w0]);
      exp_q.push_back(shadow[w1]);
    end else begin
      shadow[w0] = (shadow[w0] & ~lanes(m0)) | (d0 & lanes(m0));
      shadow[w1] = (shadow[w1] & ~lanes(m1)) | (d1 & lanes(m1));
    end
    sram_ctl_model_i.xfer(rd, a[ADDR_W-1:0], d0, d1, m0, m1, bad);
  endtask

  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Results taken off the note queue as they appear
  always @(negedge ref_clk_i) begin
    if (rd_vld === 1'b1) begin
      cmp1("read_pending", 1'b1, exp_q.size() != 0);
      if (exp_q.size() != 0) begin
        cmp36("dq_wire", exp_q.pop_front(), dq_wire);
      end
    end else begin
      cmp1("dq_oe_o", 1'b0, dq_oe);
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h0990A3AB));
    rst_n_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 16; a++) op(1'b0, a, 1'b1, 1'b0);
    for (int k = 0; k < 300; k++) begin
      op($urandom_range(1), $urandom_range(15), 1'b0,
         $urandom_range(3) == 0);
      if ($urandom_range(1) == 1) sram_ctl_model_i.idle();
    end
    repeat (4) sram_ctl_model_i.idle();
    cmp1("queue_empty", 1'b1, exp_q.size() == 0);
    close_out();
  end

  // Watchdog
  initial begin
    #(50 * 3000);
    mismatches++;
    close_out();
  end
endmodule
